/* pkg/pbt_regs.svh */
`ifndef PBT_REGS_SVH
`define PBT_REGS_SVH

`define PBT_DEVSEL_WAIT 5
`define PBT_MEM_AW 6
`define PBT_TGT_BASE 32'h1000_0000
`define PBT_M66 1'b0

`endif

/* pkg/pbt_pkg.sv */
package pbt_pkg;

  typedef enum logic [3:0]
  {
    PBT_CMD_MEM_RD = 4'h6,
    PBT_CMD_MEM_WR = 4'h7,
    PBT_CMD_CFG_RD = 4'ha,
    PBT_CMD_CFG_WR = 4'hb
  } pbt_cmd_e;

  typedef enum logic [1:0]
  {
    PBT_STS_OK,
    PBT_STS_MABORT,
    PBT_STS_RETRY,
    PBT_STS_TABORT
  } pbt_sts_e;

  typedef enum {M_IDLE, M_ADDR, M_DATA, M_TURN} pbt_mst_e;
  typedef enum {T_IDLE, T_DEC, T_DATA, T_TURN} pbt_tgt_e;

  function automatic logic pbt_par(input logic [31:0] ad,
                                   input logic [3:0] cbe);
    return ^{ad, cbe};
  endfunction

  function automatic logic pbt_is_cfg(input logic [3:0] cmd);
    return cmd[3:1] == 3'h5;
  endfunction

  function automatic logic pbt_is_mem(input logic [3:0] cmd);
    return cmd[3:1] == 3'h3;
  endfunction

endpackage

/* pkg/pbt_mem_if.sv */
interface pbt_mem_if #(parameter int AW = 6);
  logic we;
  logic [AW-1:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wbe;
  logic [AW-1:0] raddr;
  logic [31:0] rdata;
  modport ctl (output we, waddr, wdata, wbe, raddr, input rdata);
  modport mem (input we, waddr, wdata, wbe, raddr, output rdata);
endinterface

/* hw/pbt_mem.sv */
module pbt_mem
  #(parameter int AW = 6)
  (
  input wire logic clk_i,
  pbt_mem_if.mem port
  );

  logic [31:0] words [2**AW];

  // Read data is registered so the target sees it one edge after the address.
  always_ff @(posedge clk_i)
  begin
    for (int b = 0; b < 4; b++)
    begin
      if (port.we && port.wbe[b])
      begin
        words[port.waddr][8*b +: 8] <= port.wdata[8*b +: 8];
      end
    end
    port.rdata <= words[port.raddr];
  end

endmodule

/* hw/pbt_host.sv */
// What this block does
// - Command and byte enables share four active-low lane lines by phase.
// - Initiator drives the bus command on the lanes in the address phase.
// - Initiator drives active-low byte enables on the lanes per data phase.
// - Parity is even over the 32 data bits and four lane bits.
// - Initiator asserts frame at address phase, drops it before last data.
// - Master asserts initiator ready on valid write data or read readiness.
// - Target asserts target ready when read data valid or write acceptable.
// - A data phase completes on an edge with both readies asserted, or on stop or devsel timeout.
// - Select strobe, active high, chip-selects configuration transactions.
// - A target ending a transaction early asserts stop toward the master.
// - The 66 MHz enable is asserted when the segment runs at 66 MHz.
// - A read has one turnaround cycle before the target drives data.
`include "pbt_regs.svh"

module pbt_host
  import pbt_pkg::*;
  #(
  parameter int DEVSEL_WAIT = `PBT_DEVSEL_WAIT,
  parameter int MEM_AW = `PBT_MEM_AW,
  parameter logic [31:0] TGT_BASE = `PBT_TGT_BASE,
  parameter bit BUS_66MHZ = `PBT_M66
  )
  (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic pci_clk_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [3:0] req_cmd_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [31:0] req_data_i,
  input wire logic [3:0] req_be_n_i,
  output logic rsp_valid_o,
  output logic [31:0] rsp_data_o,
  output logic [1:0] rsp_status_o,
  output logic rsp_perr_o,
  input wire logic [31:0] ad_i,
  output logic [31:0] ad_o,
  output logic ad_oe_o,
  input wire logic [3:0] pci_cmd_byte_lanes_i,
  output logic [3:0] pci_cmd_byte_lanes_o,
  output logic pci_cmd_byte_lanes_oe_o,
  input wire logic par_i,
  output logic par_o,
  output logic par_oe_o,
  input wire logic frame_n_i,
  output logic frame_n_o,
  output logic frame_oe_o,
  input wire logic irdy_n_i,
  output logic irdy_n_o,
  output logic irdy_oe_o,
  input wire logic trdy_n_i,
  output logic trdy_n_o,
  output logic trdy_oe_o,
  input wire logic devsel_n_i,
  output logic devsel_n_o,
  output logic devsel_oe_o,
  input wire logic stop_n_i,
  output logic stop_n_o,
  output logic stop_oe_o,
  input wire logic perr_n_i,
  output logic perr_n_o,
  output logic perr_oe_o,
  output logic idsel_o,
  output logic m66en_o
  );

  if (DEVSEL_WAIT < 1 || DEVSEL_WAIT > 7 || MEM_AW < 1 || MEM_AW > 16)
  begin : g_chk
    $error("pbt_host: DEVSEL_WAIT must be 1..7 and MEM_AW 1..16.");
  end

  // Core side: one request in flight, its fields stay still until answered.
  logic busy, rq_tgl, dn_meta, dn_sync, dn_seen;
  logic [3:0] q_cmd, q_be_n;
  logic [31:0] q_addr, q_data;
  logic p_dn_tgl, p_perr;
  logic [31:0] p_rdata;
  pbt_sts_e p_sts;
  wire req_take = req_valid_i && !busy;
  wire dn_edge = dn_sync != dn_seen;
  wire q_wr = q_cmd[0];
  assign req_ready_o = !busy;

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      {busy, rq_tgl, dn_meta, dn_sync, dn_seen} <= 5'h00;
      {q_cmd, q_be_n, q_addr, q_data} <= 72'h0;
      {rsp_valid_o, rsp_data_o, rsp_status_o, rsp_perr_o} <= 36'h0;
    end
    else
    begin
      dn_meta <= p_dn_tgl;
      dn_sync <= dn_meta;
      dn_seen <= dn_sync;
      rsp_valid_o <= dn_edge;
      if (req_take)
      begin
        busy <= 1'b1;
        rq_tgl <= ~rq_tgl;
        {q_cmd, q_be_n, q_addr, q_data} <=
          {req_cmd_i, req_be_n_i, req_addr_i, req_data_i};
      end
      else if (dn_edge)
      begin
        busy <= 1'b0;
      end
      if (dn_edge)
      begin
        {rsp_data_o, rsp_status_o, rsp_perr_o} <= {p_rdata, p_sts, p_perr};
      end
    end
  end

  // Bus side. Its reset is released through two flops on the bus clock.
  logic p_rst_n, p_rst_meta, rq_meta, rq_sync, rq_seen, frame_q;
  always_ff @(posedge pci_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      {p_rst_meta, p_rst_n} <= 2'h0;
    end
    else
    begin
      {p_rst_meta, p_rst_n} <= {1'b1, p_rst_meta};
    end
  end

  pbt_mst_e m_state, next_m_state;
  pbt_tgt_e t_state, next_t_state;
  logic [2:0] dv_cnt;
  logic m_rd_ok, t_wr, t_exp;
  logic [MEM_AW-1:0] t_addr;
  pbt_mem_if #(.AW(MEM_AW)) mem_bus();

  wire rq_new = rq_sync != rq_seen;
  wire bus_idle = frame_n_i && irdy_n_i;
  wire m_go = m_state == M_IDLE && t_state == T_IDLE && rq_new && bus_idle;
  wire m_to = devsel_n_i && dv_cnt == 3'(DEVSEL_WAIT - 1);
  wire m_fin = !trdy_n_i || !stop_n_i || m_to;
  wire [3:0] bus_cbe = pci_cmd_byte_lanes_oe_o ? pci_cmd_byte_lanes_o
                                               : pci_cmd_byte_lanes_i;
  wire hit = pbt_is_mem(pci_cmd_byte_lanes_i)
    && ad_i[31:MEM_AW+2] == TGT_BASE[31:MEM_AW+2];
  wire t_start = t_state == T_IDLE && m_state == M_IDLE && frame_q
    && !frame_n_i && hit;
  wire t_xfer = t_state == T_DATA && !irdy_n_i;
  wire m_perr = m_state == M_TURN && m_rd_ok
    && par_i != pbt_par(p_rdata, q_be_n);
  wire t_perr = t_state == T_TURN && t_wr && par_i != t_exp;
  wire perr_hit = m_perr || t_perr;
  pbt_sts_e m_sts;
  assign m_sts = !trdy_n_i ? PBT_STS_OK
    : !stop_n_i ? (devsel_n_i ? PBT_STS_TABORT : PBT_STS_RETRY)
    : PBT_STS_MABORT;
  assign m66en_o = BUS_66MHZ;

  assign mem_bus.we = t_xfer && t_wr;
  assign mem_bus.waddr = t_addr;
  assign mem_bus.wdata = ad_i;
  assign mem_bus.wbe = ~pci_cmd_byte_lanes_i;
  assign mem_bus.raddr = t_start ? ad_i[MEM_AW+1:2] : t_addr;

  pbt_mem #(.AW(MEM_AW)) u_mem (
    .clk_i(pci_clk_i),
    .port(mem_bus.ctl)
  );

  logic [31:0] m_ad;
  logic [3:0] m_cbe;
  logic m_ad_oe, m_cbe_oe, m_frame_n, m_frame_oe, m_irdy_n, m_irdy_oe;
  logic m_idsel;

  always_comb
  begin
    next_m_state = m_state;
    m_frame_n = 1'b1;
    m_frame_oe = 1'b0;
    m_irdy_n = 1'b1;
    m_irdy_oe = 1'b0;
    m_ad = q_data;
    m_ad_oe = 1'b0;
    m_cbe = q_be_n;
    m_cbe_oe = 1'b0;
    m_idsel = 1'b0;
    unique case (m_state)
      M_IDLE:
      begin
        if (m_go)
        begin
          next_m_state = M_ADDR;
          m_frame_n = 1'b0;
          m_frame_oe = 1'b1;
          m_irdy_oe = 1'b1;
          m_ad = q_addr;
          m_ad_oe = 1'b1;
          m_cbe = q_cmd;
          m_cbe_oe = 1'b1;
          m_idsel = pbt_is_cfg(q_cmd);
        end
      end
      M_ADDR, M_DATA:
      begin
        // Single data phase, so frame is already high when ready goes low.
        m_frame_oe = 1'b1;
        m_irdy_n = 1'b0;
        m_irdy_oe = 1'b1;
        m_ad_oe = q_wr;
        m_cbe_oe = 1'b1;
        if (m_state == M_ADDR)
        begin
          next_m_state = M_DATA;
        end
        else if (m_fin)
        begin
          next_m_state = M_TURN;
          m_irdy_n = 1'b1;
          m_ad_oe = 1'b0;
          m_cbe_oe = 1'b0;
        end
      end
      M_TURN:
      begin
        next_m_state = M_IDLE;
      end
    endcase
  end

  logic t_devsel_n, t_trdy_n, t_stop_n, t_oe, t_ad_oe;

  always_comb
  begin
    next_t_state = t_state;
    t_devsel_n = 1'b1;
    t_trdy_n = 1'b1;
    t_stop_n = 1'b1;
    t_oe = 1'b0;
    t_ad_oe = 1'b0;
    unique case (t_state)
      T_IDLE:
      begin
        if (t_start)
        begin
          next_t_state = T_DEC;
        end
      end
      T_DEC, T_DATA:
      begin
        next_t_state = T_DATA;
        t_oe = 1'b1;
        t_devsel_n = 1'b0;
        t_trdy_n = 1'b0;
        t_ad_oe = !t_wr;
        // Only one word per transaction: a burst is cut short with data.
        t_stop_n = t_state == T_DEC ? frame_n_i : stop_n_o;
        if (t_xfer)
        begin
          next_t_state = T_TURN;
          t_devsel_n = 1'b1;
          t_trdy_n = 1'b1;
          t_stop_n = 1'b1;
          t_ad_oe = 1'b0;
        end
      end
      T_TURN:
      begin
        next_t_state = T_IDLE;
      end
    endcase
  end

  wire m_own = m_state != M_IDLE || m_go;

  // Every bus pin except m66en_o, which is tied to BUS_66MHZ, is launched from a flop on the rising bus clock edge.
  always_ff @(posedge pci_clk_i or negedge p_rst_n)
  begin
    if (!p_rst_n)
    begin
      {ad_o, ad_oe_o, pci_cmd_byte_lanes_o} <= 37'h0;
      {pci_cmd_byte_lanes_oe_o, par_o, par_oe_o} <= 3'h0;
      {frame_n_o, frame_oe_o, irdy_n_o, irdy_oe_o} <= 4'ha;
      {trdy_n_o, trdy_oe_o, devsel_n_o, devsel_oe_o} <= 4'ha;
      {stop_n_o, stop_oe_o, perr_n_o, perr_oe_o, idsel_o} <= 5'h14;
    end
    else
    begin
      ad_o <= m_own ? m_ad : mem_bus.rdata;
      ad_oe_o <= m_own ? m_ad_oe : t_ad_oe;
      {pci_cmd_byte_lanes_o, pci_cmd_byte_lanes_oe_o} <= {m_cbe, m_cbe_oe};
      par_o <= pbt_par(ad_o, bus_cbe);
      par_oe_o <= ad_oe_o;
      {frame_n_o, frame_oe_o, irdy_n_o, irdy_oe_o} <=
        {m_frame_n, m_frame_oe, m_irdy_n, m_irdy_oe};
      {trdy_n_o, devsel_n_o, stop_n_o} <= {t_trdy_n, t_devsel_n, t_stop_n};
      {trdy_oe_o, devsel_oe_o, stop_oe_o} <= {3{t_oe || t_state == T_DATA}};
      perr_n_o <= !perr_hit;
      perr_oe_o <= perr_hit || (perr_oe_o && !perr_n_o);
      idsel_o <= m_idsel;
    end
  end

  always_ff @(posedge pci_clk_i or negedge p_rst_n)
  begin
    if (!p_rst_n)
    begin
      {rq_meta, rq_sync, rq_seen, p_dn_tgl, frame_q} <= 5'h01;
      m_state <= M_IDLE;
      t_state <= T_IDLE;
      {dv_cnt, m_rd_ok, t_wr, t_exp, p_perr} <= 7'h00;
      {p_rdata, t_addr} <= '0;
      p_sts <= PBT_STS_OK;
    end
    else
    begin
      {rq_meta, rq_sync, frame_q} <= {rq_tgl, rq_meta, frame_n_i};
      m_state <= next_m_state;
      t_state <= next_t_state;
      dv_cnt <= m_state == M_DATA && devsel_n_i ? dv_cnt + 3'h1 : 3'h0;
      if (m_go)
      begin
        rq_seen <= rq_sync;
        p_perr <= 1'b0;
      end
      if (m_state == M_DATA && m_fin)
      begin
        p_sts <= m_sts;
        p_rdata <= ad_i;
        m_rd_ok <= !trdy_n_i && !q_wr;
      end
      if (m_state == M_TURN)
      begin
        p_perr <= m_perr;
        p_dn_tgl <= ~p_dn_tgl;
      end
      if (t_start)
      begin
        t_addr <= ad_i[MEM_AW+1:2];
        t_wr <= pci_cmd_byte_lanes_i[0];
      end
      if (t_xfer)
      begin
        t_exp <= pbt_par(ad_i, pci_cmd_byte_lanes_i);
      end
    end
  end

  cmd_addr_a: assert property (
    @(posedge pci_clk_i) disable iff (!p_rst_n)
    m_state == M_ADDR |-> !frame_n_o && pci_cmd_byte_lanes_oe_o
      && pci_cmd_byte_lanes_o == q_cmd)
    else $error("Command not on lanes in the address phase.");
  be_data_a: assert property (
    @(posedge pci_clk_i) disable iff (!p_rst_n)
    m_state == M_DATA |-> pci_cmd_byte_lanes_o == q_be_n)
    else $error("Byte enables wrong in the data phase.");
  par_even_a: assert property (
    @(posedge pci_clk_i) disable iff (!p_rst_n)
    ad_oe_o ##1 par_oe_o |-> par_o == pbt_par($past(ad_o), $past(bus_cbe)))
    else $error("Parity is not even over data and lanes.");
  frame_last_a: assert property (
    @(posedge pci_clk_i) disable iff (!p_rst_n)
    m_state == M_ADDR |-> !frame_n_o ##1 (frame_n_o && frame_oe_o
      && !irdy_n_o))
    else $error("Frame not dropped before the last data phase.");
  irdy_wr_a: assert property (
    @(posedge pci_clk_i) disable iff (!p_rst_n)
    m_state == M_DATA && q_wr |-> !irdy_n_o && ad_oe_o && ad_o == q_data)
    else $error("Initiator ready without valid write data.");
  trdy_rd_a: assert property (
    @(posedge pci_clk_i) disable iff (!p_rst_n)
    t_state == T_DATA && !t_wr |-> !trdy_n_o && ad_oe_o)
    else $error("Target ready without read data driven.");
  hs_done_a: assert property (
    @(posedge pci_clk_i) disable iff (!p_rst_n)
    m_state == M_DATA && !trdy_n_i |=> m_state == M_TURN && irdy_n_o
      ##1 m_state == M_IDLE && !irdy_oe_o)
    else $error("Data phase did not complete on both readies.");
  idsel_cfg_a: assert property (
    @(posedge pci_clk_i) disable iff (!p_rst_n)
    idsel_o |-> m_state == M_ADDR && pbt_is_cfg(q_cmd))
    else $error("Select strobe outside a configuration address.");
  stop_early_a: assert property (
    @(posedge pci_clk_i) disable iff (!p_rst_n)
    t_state == T_DEC && !frame_n_i |=> !stop_n_o && !trdy_n_o)
    else $error("Burst not stopped after the first word.");
  turn_read_a: assert property (
    @(posedge pci_clk_i) disable iff (!p_rst_n)
    m_state == M_ADDR && !q_wr |=> !ad_oe_o ##1 !ad_oe_o)
    else $error("Data driven during a read turnaround.");

  wr_done_c: cover property (@(posedge pci_clk_i) disable iff (!p_rst_n)
    m_state == M_DATA && q_wr && !trdy_n_i);
  rd_done_c: cover property (@(posedge pci_clk_i) disable iff (!p_rst_n)
    m_state == M_DATA && !q_wr && !trdy_n_i);
  mabort_c: cover property (@(posedge pci_clk_i) disable iff (!p_rst_n)
    m_state == M_DATA && m_to);
  tgt_xfer_c: cover property (@(posedge pci_clk_i) disable iff (!p_rst_n)
    t_xfer);

endmodule

/* dv/pbt_dev_model.sv */
module pbt_dev_model
  import pbt_pkg::*;
  (
  input wire logic clk_i,
  input wire logic [31:0] ad_i,
  input wire logic [3:0] cbe_i,
  input wire logic par_i,
  input wire logic frame_n_i,
  input wire logic irdy_n_i,
  input wire logic trdy_n_i,
  input wire logic devsel_n_i,
  input wire logic idsel_i,
  input wire logic perr_n_i,
  output logic [31:0] ad_o,
  output logic ad_oe_o,
  output logic [3:0] cbe_o,
  output logic cbe_oe_o,
  output logic par_o,
  output logic par_oe_o,
  output logic frame_n_o,
  output logic irdy_n_o,
  output logic trdy_n_o,
  output logic devsel_n_o,
  output logic stop_n_o
  );
  timeunit 1ns;
  timeprecision 100ps;
  // Control outputs idle at one, since the bench wires them with pull-ups.
  logic [1:0] mode = 2'h0;
  logic [2:0] wt = 3'h0;
  logic bad = 1'b0;
  logic perr_seen = 1'b0;
  logic fq = 1'b1;
  logic pchk = 1'b0;
  logic idsel_seen;
  logic [31:0] mem [4];
  logic [31:0] adr;
  logic [31:0] lad;
  logic [3:0] cmd;
  logic [3:0] be;
  logic [3:0] lbe;
  int par_errs = 0;
  int st = 0;
  int cnt;

  initial
  begin
    {ad_oe_o, cbe_oe_o, par_oe_o} = 3'h0;
    // Known contents, so a read of an unwritten word still has clean parity.
    foreach (mem[i])
      mem[i] = 32'h0;
    {frame_n_o, irdy_n_o, trdy_n_o, devsel_n_o, stop_n_o} = 5'h1f;
  end

  always @(posedge clk_i)
  begin
    fq <= frame_n_i;
    pchk <= 1'b0;
    if (!perr_n_i)
      perr_seen <= 1'b1;
    if (pchk && par_i !== ^{lad, lbe})
      par_errs <= par_errs + 1;
    if (st == 0 && !frame_n_i && fq && ad_i[31:28] == 4'h2 && mode != 2'h1)
    begin
      adr <= ad_i;
      cmd <= cbe_i;
      idsel_seen <= idsel_i;
      lad <= ad_i;
      lbe <= cbe_i;
      pchk <= 1'b1;
      cnt <= 0;
      st <= 1;
    end
    else if (st == 1 && cnt == wt + 1)
    begin
      devsel_n_o <= mode == 2'h3;
      trdy_n_o <= mode != 2'h0;
      stop_n_o <= mode == 2'h0;
      ad_o <= mem[adr[3:2]];
      ad_oe_o <= !cmd[0] && mode == 2'h0;
      st <= 2;
    end
    else if (st == 1)
      cnt <= cnt + 1;
    else if (st == 2 && ((!irdy_n_i && mode == 2'h0) ||
                         (irdy_n_i && mode != 2'h0)))
    begin
      if (cmd[0] && mode == 2'h0)
        mem[adr[3:2]] <= ad_i;
      be <= cbe_i;
      lad <= ad_i;
      lbe <= cbe_i;
      pchk <= cmd[0] && mode == 2'h0;
      par_o <= ^{ad_o, cbe_i} ^ bad;
      par_oe_o <= !cmd[0] && mode == 2'h0;
      {trdy_n_o, devsel_n_o, stop_n_o} <= 3'h7;
      ad_oe_o <= 1'b0;
      st <= 3;
    end
    else if (st == 3)
    begin
      par_oe_o <= 1'b0;
      st <= 0;
    end
  end

  task automatic init(input logic wr, input logic [31:0] a, d,
                      output logic [31:0] q, output int dl);
    int n;
    n = 0;
    dl = 0;
    @(posedge clk_i);
    frame_n_o <= 1'b0;
    ad_o <= a;
    cbe_o <= wr ? 4'h7 : 4'h6;
    {ad_oe_o, cbe_oe_o} <= 2'h3;
    @(posedge clk_i);
    frame_n_o <= 1'b1;
    irdy_n_o <= 1'b0;
    cbe_o <= 4'h0;
    ad_o <= d;
    ad_oe_o <= wr;
    par_o <= ^{a, wr ? 4'h7 : 4'h6};
    par_oe_o <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
      if (!devsel_n_i && dl == 0)
        dl = n;
      par_o <= ^{d, 4'h0};
      par_oe_o <= wr;
    end
    while (trdy_n_i && n < 8);
    q = ad_i;
    {irdy_n_o, ad_oe_o, cbe_oe_o} <= 3'h4;
    @(posedge clk_i);
    if (!wr && par_i !== ^{q, 4'h0})
      par_errs++;
    par_oe_o <= 1'b0;
  endtask
endmodule

/* dv/pci_bus_master_target_port_tb.sv */
module pci_bus_master_target_port_tb
  import pbt_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i = 1'b0;
  logic pci_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic flt = 1'b0;
  logic [3:0] req_cmd_i = 4'h0;
  logic [3:0] req_be_n_i = 4'h0;
  logic [31:0] req_addr_i = 32'h0;
  logic [31:0] req_data_i = 32'h0;
  logic req_ready_o, rsp_valid_o, rsp_perr_o, ad_oe_o, par_i, par_o;
  logic par_oe_o, pci_cmd_byte_lanes_oe_o, idsel_o, m66en_o;
  logic frame_n_i, frame_n_o, frame_oe_o, irdy_n_i, irdy_n_o, irdy_oe_o;
  logic trdy_n_i, trdy_n_o, trdy_oe_o, devsel_n_i, devsel_n_o;
  logic devsel_oe_o, stop_n_i, stop_n_o, stop_oe_o;
  logic perr_n_i, perr_n_o, perr_oe_o, dv_ad_oe, dv_cbe_oe, dv_par_oe;
  logic dv_par, dv_frame, dv_irdy, dv_trdy, dv_devsel, dv_stop;
  logic [31:0] rsp_data_o, ad_i, ad_o, dv_ad;
  logic [1:0] rsp_status_o;
  logic [3:0] pci_cmd_byte_lanes_i, pci_cmd_byte_lanes_o, dv_cbe;
  int failures = 0;
  int cmp_count = 0;

  always #25 core_clk_i = ~core_clk_i;
  always #40 pci_clk_i = ~pci_clk_i;
  // Undriven data, lane and parity lines toggle so a stale value can never pass a check.
  always @(posedge pci_clk_i) flt <= ~flt;
  assign ad_i = ad_oe_o ? ad_o : dv_ad_oe ? dv_ad : {32{flt}};
  assign pci_cmd_byte_lanes_i = pci_cmd_byte_lanes_oe_o ?
    pci_cmd_byte_lanes_o : dv_cbe_oe ? dv_cbe : {4{flt}};
  assign par_i = par_oe_o ? par_o : dv_par_oe ? dv_par : flt;
  assign frame_n_i = (frame_n_o | ~frame_oe_o) & dv_frame;
  assign irdy_n_i = (irdy_n_o | ~irdy_oe_o) & dv_irdy;
  assign trdy_n_i = (trdy_n_o | ~trdy_oe_o) & dv_trdy;
  assign devsel_n_i = (devsel_n_o | ~devsel_oe_o) & dv_devsel;
  assign stop_n_i = (stop_n_o | ~stop_oe_o) & dv_stop;
  assign perr_n_i = perr_n_o | ~perr_oe_o;

  pbt_host DUT (.core_clk_i, .arst_n_i, .pci_clk_i, .req_valid_i,
    .req_ready_o, .req_cmd_i, .req_addr_i, .req_data_i, .req_be_n_i,
    .rsp_valid_o, .rsp_data_o, .rsp_status_o, .rsp_perr_o, .ad_i, .ad_o,
    .ad_oe_o, .pci_cmd_byte_lanes_i, .pci_cmd_byte_lanes_o,
    .pci_cmd_byte_lanes_oe_o, .par_i, .par_o, .par_oe_o, .frame_n_i,
    .frame_n_o, .frame_oe_o, .irdy_n_i, .irdy_n_o, .irdy_oe_o, .trdy_n_i,
    .trdy_n_o, .trdy_oe_o, .devsel_n_i, .devsel_n_o, .devsel_oe_o,
    .stop_n_i, .stop_n_o, .stop_oe_o, .perr_n_i, .perr_n_o, .perr_oe_o,
    .idsel_o, .m66en_o);

  pbt_dev_model dev (.clk_i(pci_clk_i), .ad_i, .cbe_i(pci_cmd_byte_lanes_i),
    .par_i, .frame_n_i, .irdy_n_i, .trdy_n_i, .devsel_n_i, .idsel_i(idsel_o),
    .perr_n_i, .ad_o(dv_ad), .ad_oe_o(dv_ad_oe), .cbe_o(dv_cbe),
    .cbe_oe_o(dv_cbe_oe), .par_o(dv_par), .par_oe_o(dv_par_oe),
    .frame_n_o(dv_frame), .irdy_n_o(dv_irdy), .trdy_n_o(dv_trdy),
    .devsel_n_o(dv_devsel), .stop_n_o(dv_stop));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tx(input logic [3:0] c, input logic [31:0] a, d,
                    input logic [3:0] be);
    int n;
    n = 0;
    @(negedge core_clk_i);
    while (req_ready_o !== 1'b1 && n < 400)
    begin
      @(negedge core_clk_i);
      n++;
    end
    req_valid_i = 1'b1;
    req_cmd_i = c;
    req_addr_i = a;
    req_data_i = d;
    req_be_n_i = be;
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 400)
    begin
      @(negedge core_clk_i);
      n++;
    end
    chk("response", n < 400, 1);
  endtask

  task automatic t_cmds();
    logic [3:0] cl [4] = '{4'h6, 4'h7, 4'ha, 4'hb};
    foreach (cl[i])
    begin
      tx(cl[i], 32'h2000_000c, 32'h5a00_0000, 4'h0);
      chk("cmd", dev.cmd, cl[i]);
      chk("idsel", dev.idsel_seen, cl[i][3]);
      chk("status", rsp_status_o, PBT_STS_OK);
    end
  endtask

  task automatic t_perr();
    dev.bad = 1'b1;
    tx(PBT_CMD_MEM_RD, 32'h2000_0004, 32'h0, 4'h0);
    dev.bad = 1'b0;
    chk("rd perr bad", rsp_perr_o, 1'b1);
    chk("perr on bus", dev.perr_seen, 1'b1);
  endtask

  task automatic t_wr_rd();
    tx(PBT_CMD_MEM_WR, 32'h2000_0008, 32'ha5a5_1234, 4'h3);
    chk("wr addr", dev.adr, 32'h2000_0008);
    chk("wr be", dev.be, 4'h3);
    chk("wr data", dev.mem[2], 32'ha5a5_1234);
    dev.wt = 3'h2;
    tx(PBT_CMD_MEM_RD, 32'h2000_0008, 32'h0, 4'h0);
    dev.wt = 3'h0;
    chk("rd data", rsp_data_o, 32'ha5a5_1234);
    chk("rd perr", rsp_perr_o, 1'b0);
    chk("par errors", dev.par_errs, 0);
  endtask

  task automatic t_term();
    for (int m = 1; m < 4; m++)
    begin
      dev.mode = m[1:0];
      tx(PBT_CMD_MEM_RD, 32'h2000_0000, 32'h0, 4'h0);
      chk("end status", rsp_status_o, m);
    end
    dev.mode = 2'h0;
  endtask

  task automatic t_tgt();
    logic [31:0] q;
    int dl;
    dev.perr_seen = 1'b0;
    dev.init(1'b1, 32'h1000_0014, 32'h3c3c_0f0f, q, dl);
    chk("wr claim", dl, 2);
    dev.init(1'b0, 32'h1000_0014, 32'h0, q, dl);
    chk("rd claim", dl, 2);
    chk("tgt data", q, 32'h3c3c_0f0f);
    chk("tgt par", dev.par_errs, 0);
    chk("tgt perr", dev.perr_seen, 1'b0);
    dev.init(1'b0, 32'h1000_0400, 32'h0, q, dl);
    chk("no claim", dl, 0);
    chk("m66en", m66en_o, 1'b0);
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(negedge core_clk_i);
    arst_n_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    t_cmds();
    t_perr();
    t_wr_rd();
    t_term();
    t_tgt();
    give_verdict();
  end

  // Some forty thousand core cycles, far beyond the few hundred needed.
  initial
  begin
    #2000000;
    failures++;
    give_verdict();
  end
endmodule
